// [logic/bfc_exec.sv]
// executor for immediate test-and-clear-bit and bit-field test-and-complement
// Behaviour
// RULE_01: clear takes data-alterable modes; absolute 7/0, 7/1
// RULE_02: clear is long on register, byte on memory
// RULE_03: clear bit number from low extension byte
// RULE_04: field: flags from original, then write complement
// RULE_05: field given by starting offset and width
// RULE_06: N is field msb, V C cleared, X kept
// RULE_07: Z set when original field is all zero
// RULE_08: field modes: Dn, indirect, disp, index, absolute
// RULE_09: offset select 0 uses immediate offset 0..31
// RULE_10: offset select 1 reads register, bits 10:9 zero
// RULE_11: register offset is signed 32-bit
// RULE_12: immediate width 1..31, zero means 32
// RULE_13: register width modulo 32, bits 4:3 zero
// RULE_14: memory access covers only field bytes, 1..5
// RULE_15: bits outside field stay unchanged
// RULE_16: bit number modulo 32 register, modulo 8 memory
// RULE_17: Z from tested bit, then bit cleared
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "bfc_params.svh"
module bfc_exec (
    input  wire logic              REF_CLK,
    input  wire logic              RSTN,
    input  wire logic              S_AXI_AWVALID,
    output logic                   S_AXI_AWREADY,
    input  wire logic [7:0]        S_AXI_AWADDR,
    input  wire logic              S_AXI_WVALID,
    output logic                   S_AXI_WREADY,
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    output logic                   S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    output logic [1:0]             S_AXI_BRESP,
    input  wire logic              S_AXI_ARVALID,
    output logic                   S_AXI_ARREADY,
    input  wire logic [7:0]        S_AXI_ARADDR,
    output logic                   S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY,
    output logic [31:0]            S_AXI_RDATA,
    output logic [1:0]             S_AXI_RRESP,
    input  wire logic              INSTR_VALID,
    output logic                   INSTR_READY,
    input  wire logic [15:0]       INSTR_OPWORD,
    input  wire logic [15:0]       INSTR_EXTWORD,
    input  wire logic [31:0]       INSTR_EA,
    output logic [2:0]             DREG_SEL,
    input  wire logic [31:0]       DREG_DATA,
    output logic                   DREG_WE,
    output logic [31:0]            DREG_WDATA,
    output logic                   MEM_REQ,
    output logic                   MEM_WE,
    output logic [31:0]            MEM_ADDR,
    output logic [2:0]             MEM_SIZE,
    output bfc_pkg::bfc_win_t      MEM_WDATA,
    input  wire bfc_pkg::bfc_win_t MEM_RDATA,
    input  wire logic              MEM_ACK,
    output logic                   EXEC_DONE,
    output logic                   EXEC_ILLEGAL,
    output bfc_pkg::bfc_ccr_t      CCR_OUT
);
    import bfc_pkg::*;

    bfc_state_t  state_reg,   state_next;
    logic [15:0] op_reg,      op_next;
    logic [31:0] ea_reg,      ea_next;
    logic        clr_reg,     clr_next;
    logic        dn_reg,      dn_next;
    logic        dw_reg,      dw_next;
    logic [2:0]  wsel_reg,    wsel_next;
    logic [31:0] off_reg,     off_next;
    logic [5:0]  wid_reg,     wid_next;
    bfc_win_t    data_reg,    data_next;
    bfc_ccr_t    ccr_reg,     ccr_next;
    logic        ill_reg,     ill_next;
    logic        done_reg,    done_next;
    logic        ready_reg,   ready_next;
    logic        mreq_reg,    mreq_next;
    logic        mwe_reg,     mwe_next;
    logic [31:0] maddr_reg,   maddr_next;
    logic [2:0]  msize_reg,   msize_next;
    bfc_win_t    mwdata_reg,  mwdata_next;
    logic [2:0]  dsel_reg,    dsel_next;
    logic        dwe_reg,     dwe_next;
    logic [31:0] dwdata_reg,  dwdata_next;
    logic [31:0] count_reg,   count_next;
    logic        en_reg,      en_next;
    logic        awh_reg,     awh_next;
    logic [7:0]  awa_reg,     awa_next;
    logic        wh_reg,      wh_next;
    logic [31:0] wd_reg,      wd_next;
    logic        bv_reg,      bv_next;
    logic [1:0]  br_reg,      br_next;
    logic        rv_reg,      rv_next;
    logic [31:0] rd_reg,      rd_next;
    logic [1:0]  rr_reg,      rr_next;

    logic [31:0] g_addr;
    logic [2:0]  g_nbytes;
    bfc_win_t    g_mask;
    logic        g_msb;
    logic        g_zero;
    bfc_win_t    result;
    logic        accept;
    logic        sw_ccr_wr;
    logic [2:0]  mode;
    logic [2:0]  rnum;
    logic [15:0] ext;
    logic        is_clr;
    logic        is_fld;
    logic        mode_ok;

    // shared geometry for both operations; clear is a width-1 field
    bfc_field_geom u_geom (
        .offset    (off_reg),
        .width     (wid_reg),
        .base      (ea_reg),
        .dreg_mode (dn_reg),
        .data      (data_reg),
        .addr      (g_addr),
        .nbytes    (g_nbytes),
        .mask      (g_mask),
        .fld_msb   (g_msb),
        .fld_zero  (g_zero)
    );

    // clear forces the bit low, field op complements; outside bits pass [RULE_15]
    assign result = clr_reg ? (data_reg & ~g_mask) : (data_reg ^ g_mask);  // [RULE_04] [RULE_17]

    // decode of the offered instruction
    always_comb begin
        mode    = INSTR_OPWORD[5:3];
        rnum    = INSTR_OPWORD[2:0];
        ext     = INSTR_EXTWORD;
        is_clr  = (INSTR_OPWORD[15:6] == `BFC_OP_CLR_IMM) && (ext[15:8] == 8'h00); // [RULE_03]
        is_fld  = (INSTR_OPWORD[15:6] == `BFC_OP_FLD_CHG) && (ext[15:12] == 4'h0)
                  && !(ext[11] && ext[10:9] != 2'h0)                            // [RULE_10]
                  && !(ext[5] && ext[4:3] != 2'h0);                             // [RULE_13]
        if (mode == `BFC_EA_EXT) begin
            mode_ok = (rnum == `BFC_EA_ABS_W) || (rnum == `BFC_EA_ABS_L);       // [RULE_01] [RULE_08]
        end else if (mode == `BFC_EA_AN) begin
            mode_ok = 1'b0;
        end else if (mode == `BFC_EA_POSTINC || mode == `BFC_EA_PREDEC) begin
            mode_ok = is_clr;                                                   // [RULE_08]
        end else begin
            mode_ok = 1'b1;
        end
        accept = INSTR_VALID && ready_reg;
    end

    // execution sequencer
    always_comb begin
        state_next = state_reg;   op_next = op_reg;       ea_next = ea_reg;
        clr_next = clr_reg;       dn_next = dn_reg;       dw_next = dw_reg;
        wsel_next = wsel_reg;     off_next = off_reg;     wid_next = wid_reg;
        data_next = data_reg;     ccr_next = ccr_reg;     ill_next = ill_reg;
        done_next = 1'b0;         ready_next = ready_reg; mreq_next = mreq_reg;
        mwe_next = mwe_reg;       maddr_next = maddr_reg; msize_next = msize_reg;
        mwdata_next = mwdata_reg; dsel_next = dsel_reg;   dwe_next = 1'b0;
        dwdata_next = dwdata_reg; count_next = count_reg;
        // software write of the flags; hardware update below wins the same cycle
        if (sw_ccr_wr) begin
            ccr_next = wd_reg[4:0];
        end
        case (state_reg)
            S_IDLE: begin
                ready_next = en_reg;
                if (accept) begin
                    ready_next = 1'b0;
                    op_next    = INSTR_OPWORD;
                    ea_next    = INSTR_EA;
                    clr_next   = is_clr;
                    dn_next    = (mode == `BFC_EA_DN);
                    dw_next    = ext[5];
                    wsel_next  = ext[2:0];
                    ill_next   = !((is_clr || is_fld) && mode_ok);
                    dsel_next  = rnum;
                    // bit n is a width-1 field at offset 31-n or 7-n [RULE_16] [RULE_02]
                    if (is_clr) begin
                        wid_next = 6'h01;
                        off_next = (mode == `BFC_EA_DN) ? {27'h0, ~ext[4:0]} : {29'h0, ~ext[2:0]};
                    end else begin
                        wid_next = (ext[4:0] == 5'h00) ? 6'h20 : {1'b0, ext[4:0]}; // [RULE_12]
                        off_next = {27'h0, ext[10:6]};                          // [RULE_09]
                    end
                    if (!((is_clr || is_fld) && mode_ok)) begin
                        state_next = S_DONE;
                    end else if (is_fld && ext[11]) begin
                        dsel_next  = ext[8:6];                                  // [RULE_10]
                        state_next = S_OFF;
                    end else if (is_fld && ext[5]) begin
                        dsel_next  = ext[2:0];
                        state_next = S_WID;
                    end else begin
                        state_next = (mode == `BFC_EA_DN) ? S_DEST : S_MRD;
                    end
                end
            end
            S_OFF: begin
                off_next  = DREG_DATA;                                          // [RULE_11]
                dsel_next = dw_reg ? wsel_reg : op_reg[2:0];
                if (dw_reg) begin
                    state_next = S_WID;
                end else begin
                    state_next = dn_reg ? S_DEST : S_MRD;
                end
            end
            S_WID: begin
                wid_next   = (DREG_DATA[4:0] == 5'h00) ? 6'h20 : {1'b0, DREG_DATA[4:0]}; // [RULE_13]
                dsel_next  = op_reg[2:0];
                state_next = dn_reg ? S_DEST : S_MRD;
            end
            S_DEST: begin
                data_next  = {DREG_DATA, 8'h00};                                // [RULE_02]
                state_next = S_MWR;
            end
            S_MRD: begin
                // read only the bytes that hold the field [RULE_14]
                mreq_next  = !(mreq_reg && MEM_ACK);
                mwe_next   = 1'b0;
                maddr_next = g_addr;
                msize_next = g_nbytes;
                if (mreq_reg && MEM_ACK) begin
                    data_next  = MEM_RDATA;
                    state_next = S_MWR;
                end
            end
            S_MWR: begin
                // flags from the original field, result written after [RULE_04]
                if (!mreq_reg && !dwe_reg) begin
                    if (clr_reg) begin
                        ccr_next[`BFC_CCR_Z] = g_zero;                          // [RULE_17]
                    end else begin
                        ccr_next[`BFC_CCR_N] = g_msb;                           // [RULE_06]
                        ccr_next[`BFC_CCR_Z] = g_zero;                          // [RULE_07]
                        ccr_next[`BFC_CCR_V] = 1'b0;
                        ccr_next[`BFC_CCR_C] = 1'b0;
                        ccr_next[`BFC_CCR_X] = ccr_reg[`BFC_CCR_X];
                    end
                    if (dn_reg) begin
                        dwe_next    = 1'b1;
                        dwdata_next = result[39:8];
                        state_next  = S_DONE;
                    end else begin
                        mreq_next   = 1'b1;
                        mwe_next    = 1'b1;
                        mwdata_next = result;
                    end
                end else if (mreq_reg && MEM_ACK) begin
                    mreq_next  = 1'b0;
                    mwe_next   = 1'b0;
                    state_next = S_DONE;
                end
            end
            S_DONE: begin
                done_next  = 1'b1;
                count_next = count_reg + 32'h0000_0001;
                ready_next = en_reg;
                state_next = S_IDLE;
            end
            default: state_next = S_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            state_reg <= S_IDLE;       op_reg <= 16'h0000;     ea_reg <= 32'h0000_0000;
            clr_reg <= 1'b0;           dn_reg <= 1'b0;         dw_reg <= 1'b0;
            wsel_reg <= 3'h0;          off_reg <= 32'h0000_0000;
            wid_reg <= 6'h01;          data_reg <= 40'h00_0000_0000;
            ccr_reg <= `BFC_CCR_RST;   ill_reg <= 1'b0;        done_reg <= 1'b0;
            ready_reg <= 1'b0;         mreq_reg <= 1'b0;       mwe_reg <= 1'b0;
            maddr_reg <= 32'h0000_0000; msize_reg <= 3'h1;
            mwdata_reg <= 40'h00_0000_0000;
            dsel_reg <= 3'h0;          dwe_reg <= 1'b0;        dwdata_reg <= 32'h0000_0000;
            count_reg <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;   op_reg <= op_next;      ea_reg <= ea_next;
            clr_reg <= clr_next;       dn_reg <= dn_next;      dw_reg <= dw_next;
            wsel_reg <= wsel_next;     off_reg <= off_next;    wid_reg <= wid_next;
            data_reg <= data_next;     ccr_reg <= ccr_next;    ill_reg <= ill_next;
            done_reg <= done_next;     ready_reg <= ready_next; mreq_reg <= mreq_next;
            mwe_reg <= mwe_next;       maddr_reg <= maddr_next; msize_reg <= msize_next;
            mwdata_reg <= mwdata_next; dsel_reg <= dsel_next;  dwe_reg <= dwe_next;
            dwdata_reg <= dwdata_next; count_reg <= count_next;
        end
    end

    // axi4-lite slave: address and data taken in either order, one write at a time
    always_comb begin
        awh_next = awh_reg;  awa_next = awa_reg;  wh_next = wh_reg;  wd_next = wd_reg;
        bv_next = bv_reg;    br_next = br_reg;    rv_next = rv_reg;
        rd_next = rd_reg;    rr_next = rr_reg;    en_next = en_reg;  sw_ccr_wr = 1'b0;
        if (S_AXI_AWVALID && !awh_reg) begin
            awh_next = 1'b1;
            awa_next = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !wh_reg) begin
            wh_next = 1'b1;
            wd_next = S_AXI_WDATA;
        end
        if (awh_reg && wh_reg && !bv_reg) begin
            awh_next = 1'b0;
            wh_next  = 1'b0;
            bv_next  = 1'b1;
            br_next  = `BFC_RESP_OKAY;
            // strobes ignored: every field here fits the low byte
            if (awa_reg[7:2] == `BFC_REG_CTRL >> 2) begin
                en_next = wd_reg[`BFC_CTRL_EN_BIT];
            end else if (awa_reg[7:2] == `BFC_REG_CCR >> 2) begin
                sw_ccr_wr = 1'b1;
            end else if (awa_reg[7:2] != `BFC_REG_STATUS >> 2
                         && awa_reg[7:2] != `BFC_REG_COUNT >> 2) begin
                br_next = `BFC_RESP_DECERR;
            end
        end else if (bv_reg && S_AXI_BREADY) begin
            bv_next = 1'b0;
        end
        if (S_AXI_ARVALID && !rv_reg) begin
            rv_next = 1'b1;
            rr_next = `BFC_RESP_OKAY;
            if (S_AXI_ARADDR[7:2] == `BFC_REG_CTRL >> 2) begin
                rd_next = {31'h0, en_reg};
            end else if (S_AXI_ARADDR[7:2] == `BFC_REG_STATUS >> 2) begin
                rd_next = {28'h0, 1'b0, state_reg};
                rd_next[8] = ill_reg;
            end else if (S_AXI_ARADDR[7:2] == `BFC_REG_CCR >> 2) begin
                rd_next = {27'h0, ccr_reg};
            end else if (S_AXI_ARADDR[7:2] == `BFC_REG_COUNT >> 2) begin
                rd_next = count_reg;
            end else begin
                rd_next = 32'h0000_0000;
                rr_next = `BFC_RESP_DECERR;
            end
        end else if (rv_reg && S_AXI_RREADY) begin
            rv_next = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            awh_reg <= 1'b0;  awa_reg <= 8'h00;  wh_reg <= 1'b0;  wd_reg <= 32'h0000_0000;
            bv_reg <= 1'b0;   br_reg <= 2'h0;    rv_reg <= 1'b0;  rd_reg <= 32'h0000_0000;
            rr_reg <= 2'h0;   en_reg <= `BFC_CTRL_RST;
            S_AXI_AWREADY <= 1'b1; S_AXI_WREADY <= 1'b1; S_AXI_ARREADY <= 1'b1;
        end else begin
            awh_reg <= awh_next; awa_reg <= awa_next; wh_reg <= wh_next; wd_reg <= wd_next;
            bv_reg <= bv_next;   br_reg <= br_next;   rv_reg <= rv_next; rd_reg <= rd_next;
            rr_reg <= rr_next;   en_reg <= en_next;
            S_AXI_AWREADY <= !awh_next; S_AXI_WREADY <= !wh_next; S_AXI_ARREADY <= !rv_next;
        end
    end

    // every output straight from a flip-flop
    assign S_AXI_BVALID  = bv_reg;
    assign S_AXI_BRESP   = br_reg;
    assign S_AXI_RVALID  = rv_reg;
    assign S_AXI_RDATA   = rd_reg;
    assign S_AXI_RRESP   = rr_reg;
    assign INSTR_READY   = ready_reg;
    assign DREG_SEL      = dsel_reg;
    assign DREG_WE       = dwe_reg;
    assign DREG_WDATA    = dwdata_reg;
    assign MEM_REQ       = mreq_reg;
    assign MEM_WE        = mwe_reg;
    assign MEM_ADDR      = maddr_reg;
    assign MEM_SIZE      = msize_reg;
    assign MEM_WDATA     = mwdata_reg;
    assign EXEC_DONE     = done_reg;
    assign EXEC_ILLEGAL  = ill_reg;
    assign CCR_OUT       = ccr_reg;

    // checks
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);

    AST_CLR_AN_REJECT: assert property (accept && is_clr && mode == `BFC_EA_AN |=> ##[0:1] (EXEC_DONE && EXEC_ILLEGAL)) else $error("clear with An not rejected"); // [RULE_01]
    AST_CLR_MEM_BYTE: assert property (MEM_REQ && clr_reg |-> MEM_SIZE == 3'h1) else $error("clear memory access not one byte"); // [RULE_02]
    AST_CLR_EXT_HI: assert property (accept && INSTR_OPWORD[15:6] == `BFC_OP_CLR_IMM && INSTR_EXTWORD[15:8] != 8'h00 |=> ill_reg) else $error("bad clear extension accepted"); // [RULE_03]
    AST_FLD_COMPL: assert property (MEM_REQ && MEM_WE && !clr_reg |-> (MEM_WDATA & g_mask) == (~data_reg & g_mask)) else $error("field not complemented"); // [RULE_04]
    AST_FLD_VC: assert property (EXEC_DONE && !EXEC_ILLEGAL && !clr_reg && !$past(sw_ccr_wr, 2) |-> CCR_OUT[1:0] == 2'h0) else $error("V or C not cleared"); // [RULE_06]
    AST_FLD_POSTINC: assert property (accept && INSTR_OPWORD[15:6] == `BFC_OP_FLD_CHG && mode == `BFC_EA_POSTINC |=> ill_reg && state_reg == S_DONE) else $error("postincrement field accepted"); // [RULE_08]
    AST_WID_REG: assert property (state_reg == S_WID |=> wid_reg == (($past(DREG_DATA[4:0]) == 5'h00) ? 6'h20 : {1'b0, $past(DREG_DATA[4:0])})) else $error("register width wrong"); // [RULE_13]
    AST_MEM_SIZE: assert property (MEM_REQ |-> MEM_SIZE >= 3'h1 && MEM_SIZE <= 3'h5) else $error("memory size out of range"); // [RULE_14]
    AST_OUTSIDE: assert property (MEM_REQ && MEM_WE |-> ((MEM_WDATA ^ data_reg) & ~g_mask) == 40'h00_0000_0000) else $error("bits outside field changed"); // [RULE_15]
    AST_CLR_ZERO: assert property (MEM_REQ && MEM_WE && clr_reg |-> (MEM_WDATA & g_mask) == 40'h00_0000_0000) else $error("bit not cleared"); // [RULE_17]
    AST_REQ_HOLD: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_SIZE)) else $error("memory request dropped"); // [RULE_14]

    COV_CLR_DN: cover property (accept && is_clr && mode == `BFC_EA_DN ##[1:4] EXEC_DONE);
    COV_FLD_FIVE: cover property (MEM_REQ && MEM_WE && MEM_SIZE == 3'h5);
    COV_FLD_REGS: cover property (state_reg == S_OFF ##1 state_reg == S_WID);
    COV_ILLEGAL: cover property (EXEC_DONE && EXEC_ILLEGAL);
endmodule // bfc_exec

// [logic/bfc_params.svh]
// constants for the bit clear / bit-field complement executor
`ifndef BFC_PARAMS_SVH
`define BFC_PARAMS_SVH

// register byte offsets
`define BFC_REG_CTRL    8'h00
`define BFC_REG_STATUS  8'h04
`define BFC_REG_CCR     8'h08
`define BFC_REG_COUNT   8'h0C

// reset values
`define BFC_CTRL_RST    1'h1
`define BFC_CCR_RST     5'h00

// field positions
`define BFC_CTRL_EN_BIT 0
`define BFC_CCR_X       4
`define BFC_CCR_N       3
`define BFC_CCR_Z       2
`define BFC_CCR_V       1
`define BFC_CCR_C       0

// opcode patterns, upper ten bits of the operation word
`define BFC_OP_CLR_IMM  10'h023
`define BFC_OP_FLD_CHG  10'h3AB

// effective address modes and the mode-7 register codes
`define BFC_EA_DN       3'h0
`define BFC_EA_AN       3'h1
`define BFC_EA_IND      3'h2
`define BFC_EA_POSTINC  3'h3
`define BFC_EA_PREDEC   3'h4
`define BFC_EA_DISP16   3'h5
`define BFC_EA_INDEX    3'h6
`define BFC_EA_EXT      3'h7
`define BFC_EA_ABS_W    3'h0
`define BFC_EA_ABS_L    3'h1

// axi answers
`define BFC_RESP_OKAY   2'h0
`define BFC_RESP_DECERR 2'h3

`endif

// [logic/bfc_pkg.sv]
// types shared by the bit clear / bit-field complement executor
package bfc_pkg;
    typedef enum logic [2:0] {
        S_IDLE, S_OFF, S_WID, S_DEST, S_MRD, S_MWR, S_DONE
    } bfc_state_t;
    typedef logic [4:0]  bfc_ccr_t;
    typedef logic [39:0] bfc_win_t;
endpackage

// [logic/bfc_field_geom.sv]
// field geometry: bytes touched, mask and original-field flags
`timescale 1ns/100ps
module bfc_field_geom (
    input  wire logic [31:0]      offset,
    input  wire logic [5:0]       width,
    input  wire logic [31:0]      base,
    input  wire logic             dreg_mode,
    input  wire bfc_pkg::bfc_win_t data,
    output logic [31:0]           addr,
    output logic [2:0]            nbytes,
    output bfc_pkg::bfc_win_t     mask,
    output logic                  fld_msb,
    output logic                  fld_zero
);
    import bfc_pkg::*;

    logic [2:0]  off7;
    logic [4:0]  off5;
    logic [5:0]  span;
    logic [31:0] m32;
    logic [31:0] m32_rot;
    logic [5:0]  rot_l;
    bfc_win_t    m40;
    logic [5:0]  pos;

    // offset counts from the msb; signed offset walks whole bytes [RULE_11]
    always_comb begin
        off7    = offset[2:0];
        off5    = offset[4:0];
        addr    = base + {{3{offset[31]}}, offset[31:3]};
        span    = 6'(off7) + width + 6'h07;
        nbytes  = span[5:3];                              // 1..5 bytes only [RULE_14]
        m40     = ~(40'hFF_FFFF_FFFF >> width);           // top width bits set [RULE_05]
        m32     = ~(32'hFFFF_FFFF >> width);
        rot_l   = 6'h20 - 6'(off5);
        m32_rot = (m32 >> off5) | (m32 << rot_l);         // register field wraps round
        if (dreg_mode) begin
            mask = {m32_rot, 8'h00};
            pos  = 6'(off5);
        end else begin
            mask = m40 >> off7;
            pos  = 6'(off7);
        end
        fld_msb  = data[6'd39 - pos];                     // [RULE_06]
        fld_zero = ((data & mask) == 40'h00_0000_0000);   // [RULE_07]
    end
endmodule // bfc_field_geom

// [tb/bfc_partner.sv]
// register file and byte memory on the far side of the executor
`timescale 1ns/100ps
module bfc_partner (
    input  wire logic              REF_CLK,
    input  wire logic [2:0]        DREG_SEL,
    output logic [31:0]            DREG_DATA,
    input  wire logic              DREG_WE,
    input  wire logic [31:0]       DREG_WDATA,
    input  wire logic              MEM_REQ,
    input  wire logic              MEM_WE,
    input  wire logic [31:0]       MEM_ADDR,
    input  wire logic [2:0]        MEM_SIZE,
    input  wire bfc_pkg::bfc_win_t MEM_WDATA,
    output bfc_pkg::bfc_win_t      MEM_RDATA,
    output logic                   MEM_ACK
);
    import bfc_pkg::*;
    logic [31:0] dreg [8] = '{default: '0};
    logic [7:0]  mem [16] = '{default: '0};
    logic [2:0]  last_size = '0;
    logic [1:0]  wait_cnt = '0;
    logic        slow = 1'h0;
    assign DREG_DATA = dreg[DREG_SEL];
    initial MEM_ACK = 1'h0;
    initial MEM_RDATA = '0;
    // answers alternate prompt and slow; read data churns outside an answer
    always @(posedge REF_CLK) begin
        MEM_ACK <= 1'h0;
        MEM_RDATA <= ~MEM_RDATA;
        if (MEM_REQ && !MEM_ACK && wait_cnt != 0) wait_cnt <= wait_cnt - 2'h1;
        else if (MEM_REQ && !MEM_ACK) begin
            MEM_ACK <= 1'h1;
            last_size <= MEM_SIZE;
            slow <= !slow;
            wait_cnt <= slow ? 2'h0 : 2'h2;
            for (int i = 0; i < 5; i++) begin
                MEM_RDATA[39-8*i -: 8] <= mem[4'(MEM_ADDR[3:0] + i)];
                if (MEM_WE && i < MEM_SIZE) mem[4'(MEM_ADDR[3:0] + i)] <= MEM_WDATA[39-8*i -: 8];
            end
        end
        if (DREG_WE) dreg[DREG_SEL] <= DREG_WDATA;
    end
endmodule // bfc_partner

// [tb/testbench.sv]
// self-checking bench for the bit clear / field complement executor
`timescale 1ns/100ps
`include "bfc_params.svh"
module testbench;
    import bfc_pkg::*;
    logic REF_CLK = 0, RSTN = 0, S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
    logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0, INSTR_VALID = 0, S_AXI_AWREADY, S_AXI_WREADY;
    logic S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, INSTR_READY, DREG_WE, MEM_REQ, MEM_WE;
    logic MEM_ACK, EXEC_DONE, EXEC_ILLEGAL;
    logic [7:0]  S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
    logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA, DREG_DATA, DREG_WDATA, MEM_ADDR, INSTR_EA = 0;
    logic [3:0]  S_AXI_WSTRB = 4'hF;
    logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
    logic [15:0] INSTR_OPWORD = 0, INSTR_EXTWORD = 0;
    logic [2:0]  DREG_SEL, MEM_SIZE;
    bfc_win_t    MEM_WDATA, MEM_RDATA;
    bfc_ccr_t    CCR_OUT;
    int          err_count = 0, n_checks = 0;
    bfc_exec dut_u (.*);
    bfc_partner ptn_u (.*);
    always #5 REF_CLK = !REF_CLK;
    task automatic chk(input logic [39:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // write both channels together, hold bready until the answer
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw = 1, w = 1;
        S_AXI_AWADDR <= a; S_AXI_WDATA <= d; S_AXI_AWVALID <= 1; S_AXI_WVALID <= 1;
        S_AXI_BREADY <= 1;
        while (aw || w) begin
            @(posedge REF_CLK);
            if (S_AXI_AWREADY) aw = 0;
            if (S_AXI_WREADY) w = 0;
            S_AXI_AWVALID <= aw; S_AXI_WVALID <= w;
        end
        do @(posedge REF_CLK); while (!S_AXI_BVALID);
        chk(S_AXI_BRESP, `BFC_RESP_OKAY);
        S_AXI_BREADY <= 0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        S_AXI_ARADDR <= a; S_AXI_ARVALID <= 1; S_AXI_RREADY <= 1;
        do @(posedge REF_CLK); while (!S_AXI_ARREADY);
        S_AXI_ARVALID <= 0;
        do @(posedge REF_CLK); while (!S_AXI_RVALID);
        d = S_AXI_RDATA; r = S_AXI_RRESP; S_AXI_RREADY <= 0;
    endtask
    // offer one instruction and wait for its completion pulse
    task automatic run(input logic [15:0] op, ext, input logic [31:0] ea);
        INSTR_OPWORD <= op; INSTR_EXTWORD <= ext; INSTR_EA <= ea; INSTR_VALID <= 1;
        do @(posedge REF_CLK); while (!INSTR_READY);
        INSTR_VALID <= 0;
        do @(posedge REF_CLK); while (!EXEC_DONE);
    endtask
    task automatic t_clr;
        ptn_u.dreg[1] = 32'h8000_0000;
        ptn_u.mem[5] = 8'h0F;
        run({`BFC_OP_CLR_IMM, 6'o01}, 16'h001F, 0);
        chk(ptn_u.dreg[1], 0);
        chk(CCR_OUT[`BFC_CCR_Z], 0);
        run({`BFC_OP_CLR_IMM, 6'o70}, 16'h000B, 5);
        chk(ptn_u.mem[5], 8'h07);
    endtask
    task automatic t_bad;
        logic [15:0] ops [4] = '{{`BFC_OP_CLR_IMM, 6'o11}, {`BFC_OP_CLR_IMM, 6'o74},
                                 {`BFC_OP_FLD_CHG, 6'o30}, {`BFC_OP_CLR_IMM, 6'o02}};
        for (int i = 0; i < 4; i++) begin
            run(ops[i], (i == 3) ? 16'h0103 : 16'h0001, 0);
            chk(EXEC_ILLEGAL, 1);
        end
    endtask
    task automatic t_fld;
        logic [31:0] d;
        logic [1:0]  r;
        axi_wr(`BFC_REG_CCR, 32'h13);
        ptn_u.dreg[2] = 32'h0800_0000;
        run({`BFC_OP_FLD_CHG, 6'o02}, 16'h0108, 0);
        chk(ptn_u.dreg[2], 32'h07F0_0000);
        axi_rd(`BFC_REG_CCR, d, r);
        chk(d, 32'h18);
        run({`BFC_OP_FLD_CHG, 6'o71}, 16'h0100, 0);
        chk({ptn_u.last_size, ptn_u.mem[0], ptn_u.mem[2], ptn_u.mem[4]}, 27'h50FFFF0);
        chk(CCR_OUT, 5'h14);
        ptn_u.dreg[3] = 32'hFFFF_FFF8;
        ptn_u.dreg[4] = 32'd36;
        run({`BFC_OP_FLD_CHG, 6'o20}, 16'h08E4, 8);
        chk({ptn_u.last_size, ptn_u.mem[7], ptn_u.mem[8]}, 19'h1F000);
        axi_rd(8'h40, d, r);
        chk({d, r}, {32'h0, `BFC_RESP_DECERR});
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge REF_CLK);
        RSTN <= 1;
        @(posedge REF_CLK);
        t_clr;
        t_bad;
        t_fld;
        end_sim;
    end
    // cut a hang short well beyond the expected run
    initial begin
        repeat (5000) @(posedge REF_CLK);
        err_count++;
        end_sim;
    end
endmodule // testbench
